// ===== logic/dmacc_arb.sv
`timescale 1ns/1ps
module dmacc_arb #(
    parameter int N = 4,
    parameter int W = 2
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic [N-1:0] req, // pending channel requests
    input wire logic take, // engine can accept a grant
    output logic gnt, // one-cycle grant pulse
    output logic [W-1:0] gnt_idx // granted channel
);
    logic [W-1:0] pick;

    // lowest channel number wins; fixed priority keeps timing simple
    always_comb begin
        pick = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick = W'(i);
            end
        end
    end

    // registered grant, never two in a row
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gnt <= 1'b0;
            gnt_idx <= '0;
        end else begin
            gnt <= take && (|req) && !gnt;
            if (take && (|req) && !gnt) begin
                gnt_idx <= pick;
            end
        end
    end
endmodule : dmacc_arb

// ===== logic/dmacc_chan.sv
`timescale 1ns/1ps
module dmacc_chan
    import dmacc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic start, // channel just enabled
    input wire logic step, // one transfer of this channel finished
    input wire logic [1:0] mode, // operating mode
    input wire logic half_sel, // interrupt at half block
    input wire logic [15:0] cnt, // transfers per block minus one
    output logic [15:0] idx, // transfers done in this block
    output logic buf_b, // second ping-pong buffer in use
    output logic blk_evt, // block interrupt event
    output logic stop // channel must disable itself
);
    logic last;
    logic halfpt;

    assign last = step && (idx == cnt);
    assign halfpt = step && (idx == (cnt >> 1));
    assign blk_evt = half_sel ? halfpt : last;
    // stop after buffer B; one-shot stop
    assign stop = last && ((mode == MODE_ONE) || ((mode == MODE_PP_ONE) && buf_b));

    // block position counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx <= 16'h0000;
        end else if (start || last) begin
            idx <= 16'h0000;
        end else if (step) begin
            idx <= idx + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_b <= 1'b0;
        end else if (start) begin
            buf_b <= 1'b0;
        end else if (last && mode[1]) begin
            buf_b <= ~buf_b;
        end
    end
endmodule : dmacc_chan

// ===== logic/dmacc_pkg.sv
package dmacc_pkg;
    // per-channel register window
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [2:0] IDX_CON = 3'h0;
    localparam logic [2:0] IDX_RAM_A = 3'h1;
    localparam logic [2:0] IDX_RAM_B = 3'h2;
    localparam logic [2:0] IDX_PADR = 3'h3;
    localparam logic [2:0] IDX_CNT = 3'h4;
    // global registers
    localparam logic [7:0] OFS_LCA = 8'h80;
    localparam logic [7:0] OFS_INT_STAT = 8'h84;
    localparam logic [7:0] OFS_INT_MASK = 8'h88;
    // control field positions
    localparam int CON_EN = 15;
    localparam int CON_SIZE = 14;
    localparam int CON_DIR = 13;
    localparam int CON_HALF = 12;
    localparam int CON_NULL_PERIPHERAL_WRITE = 11;
    localparam int CON_AM_LSB = 4;
    localparam int CON_MODE_LSB = 0;
    localparam logic [15:0] CON_WMASK = 16'hF833;
    localparam logic [15:0] CON_RST = 16'h0000;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [3:0] LCA_RST = 4'hF;
    localparam logic [15:0] BYTE_MASK = 16'h00FF;
    localparam logic [15:0] NULL_DATA = 16'h0000;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    // operating modes
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_ONE = 2'h1;
    localparam logic [1:0] MODE_PP_CONT = 2'h2;
    localparam logic [1:0] MODE_PP_ONE = 2'h3;
    // addressing modes
    localparam logic [1:0] AM_INC = 2'h0;
    localparam logic [1:0] AM_NOINC = 2'h1;
    localparam logic [1:0] AM_PIA = 2'h2;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_RD = 4'b0010,
        S_WR = 4'b0100,
        S_NUL = 4'b1000
    } dmacc_state_t;
endpackage : dmacc_pkg

// ===== logic/dmacc_top.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module dmacc_top
    import dmacc_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic clk, // system clock, 40 MHz
    input wire logic nrst, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic irq, // level interrupt
    input wire logic [NCH-1:0] xfer_req, // peripheral transfer request pulses
    input wire logic [15:0] pia_addr, // RAM address from peripheral
    output logic bus_req, // transfer cycle active
    output logic bus_we, // write cycle
    output logic bus_periph, // peripheral space, else RAM
    output logic bus_byte, // byte wide cycle
    output logic [15:0] bus_addr, // cycle address
    output logic [15:0] bus_wdata, // write data
    input wire logic [15:0] bus_rdata, // read data, valid with ack
    input wire logic bus_ack // cycle completes
);
    localparam int CW = 2;

    logic [15:0] con [NCH];
    logic [15:0] ram_a [NCH];
    logic [15:0] ram_b [NCH];
    logic [15:0] padr [NCH];
    logic [15:0] cnt [NCH];
    logic [15:0] idx [NCH];
    logic [NCH-1:0] buf_b;
    logic [NCH-1:0] blk_evt;
    logic [NCH-1:0] stop;
    logic [NCH-1:0] start;
    logic [NCH-1:0] step;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] int_stat;
    logic [NCH-1:0] int_mask;
    logic [3:0] lca;
    logic gnt;
    logic [CW-1:0] gnt_idx;
    logic [CW-1:0] cur;
    dmacc_state_t state;
    logic xfer_done;
    logic [15:0] ram_cur;
    logic [15:0] per_cur;
    logic dir_cur;
    logic null_cur;
    logic [15:0] next_ram;
    logic apb_wr;
    logic apb_rd_phase;
    logic glb;
    logic [CW-1:0] sel_ch;
    logic [2:0] sel_reg;
    logic mapped;
    logic [31:0] next_rdata;

    // address decode: low half is channel windows, high half global
    assign glb = paddr[7];
    assign sel_ch = paddr[6:5];
    assign sel_reg = paddr[4:2];
    assign mapped = glb ? (paddr == OFS_LCA || paddr == OFS_INT_STAT || paddr == OFS_INT_MASK)
                        : (sel_reg <= IDX_CNT && 32'(sel_ch) < NCH);
    assign apb_rd_phase = psel && penable && !pready;
    assign apb_wr = psel && penable && pready && pwrite && mapped;

    // one wait state; ready, data and error come from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_rd_phase;
            pslverr <= apb_rd_phase && !mapped;
            if (apb_rd_phase && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // read mux, unused upper bits read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (glb) begin
            unique case (paddr)
                OFS_LCA: next_rdata = {28'h000_0000, lca};
                OFS_INT_STAT: next_rdata = 32'(int_stat);
                OFS_INT_MASK: next_rdata = 32'(int_mask);
                default: next_rdata = 32'h0000_0000;
            endcase
        end else if (32'(sel_ch) < NCH) begin
            unique case (sel_reg)
                IDX_CON: next_rdata = {16'h0000, con[sel_ch]};
                IDX_RAM_A: next_rdata = {16'h0000, ram_a[sel_ch]};
                IDX_RAM_B: next_rdata = {16'h0000, ram_b[sel_ch]};
                IDX_PADR: next_rdata = {16'h0000, padr[sel_ch]};
                IDX_CNT: next_rdata = {16'h0000, cnt[sel_ch]};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gch
            logic hit;
            assign hit = apb_wr && !glb && (32'(sel_ch) == g);

            // control word; a software write beats the hardware self-clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    con[g] <= CON_RST;
                    start[g] <= 1'b0;
                end else begin
                    start[g] <= hit && sel_reg == IDX_CON && pwdata[CON_EN] && !con[g][CON_EN];
                    if (hit && sel_reg == IDX_CON) begin
                        con[g] <= pwdata[15:0] & CON_WMASK;
                    end else if (stop[g]) begin
                        con[g][CON_EN] <= 1'b0;
                    end
                end
            end

            // address and count registers
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ram_a[g] <= ADDR_RST;
                    ram_b[g] <= ADDR_RST;
                    padr[g] <= ADDR_RST;
                    cnt[g] <= ADDR_RST;
                end else if (hit) begin
                    if (sel_reg == IDX_RAM_A) ram_a[g] <= pwdata[15:0];
                    if (sel_reg == IDX_RAM_B) ram_b[g] <= pwdata[15:0];
                    if (sel_reg == IDX_PADR) padr[g] <= pwdata[15:0];
                    if (sel_reg == IDX_CNT) cnt[g] <= pwdata[15:0];
                end
            end

            // requests only count while enabled; a new request wins over the grant clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pend[g] <= 1'b0;
                end else if (!con[g][CON_EN]) begin
                    pend[g] <= 1'b0;
                end else if (xfer_req[g]) begin
                    pend[g] <= 1'b1;
                end else if (gnt && gnt_idx == CW'(g)) begin
                    pend[g] <= 1'b0;
                end
            end

            assign step[g] = xfer_done && (cur == CW'(g));

            dmacc_chan u_chan (
                .clk(clk),
                .nrst(nrst),
                .start(start[g]),
                .step(step[g]),
                .mode(con[g][CON_MODE_LSB +: 2]),
                .half_sel(con[g][CON_HALF]),
                .cnt(cnt[g]),
                .idx(idx[g]),
                .buf_b(buf_b[g]),
                .blk_evt(blk_evt[g]),
                .stop(stop[g])
            );
        end
    endgenerate

    dmacc_arb #(.N(NCH), .W(CW)) u_arb (
        .clk(clk),
        .nrst(nrst),
        .req(pend),
        .take(state == S_IDLE),
        .gnt(gnt),
        .gnt_idx(gnt_idx)
    );

    // RAM address for the granted channel
    always_comb begin
        logic [15:0] base;
        logic [15:0] stp;
        base = buf_b[gnt_idx] ? ram_b[gnt_idx] : ram_a[gnt_idx];
        stp = con[gnt_idx][CON_SIZE] ? STEP_BYTE : STEP_WORD;
        next_ram = base;
        unique case (con[gnt_idx][CON_AM_LSB +: 2])
            AM_INC: next_ram = base + 16'(idx[gnt_idx] * stp);
            AM_NOINC: next_ram = base;
            AM_PIA: next_ram = pia_addr;
            default: next_ram = base;
        endcase
    end

    assign xfer_done = bus_ack && ((state == S_WR && !null_cur) || state == S_NUL);

    // transfer engine: read source, write destination, optional null write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
            cur <= '0;
            ram_cur <= ADDR_RST;
            per_cur <= ADDR_RST;
            dir_cur <= 1'b0;
            null_cur <= 1'b0;
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            bus_periph <= 1'b0;
            bus_byte <= 1'b0;
            bus_addr <= ADDR_RST;
            bus_wdata <= NULL_DATA;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (gnt && con[gnt_idx][CON_EN]) begin
                        state <= S_RD;
                        cur <= gnt_idx;
                        ram_cur <= next_ram;
                        per_cur <= padr[gnt_idx];
                        dir_cur <= con[gnt_idx][CON_DIR];
                        // null write only with direction clear
                        null_cur <= con[gnt_idx][CON_NULL_PERIPHERAL_WRITE] && !con[gnt_idx][CON_DIR];
                        bus_req <= 1'b1;
                        bus_we <= 1'b0;
                        bus_byte <= con[gnt_idx][CON_SIZE];
                        bus_periph <= !con[gnt_idx][CON_DIR];
                        bus_addr <= con[gnt_idx][CON_DIR] ? next_ram : padr[gnt_idx];
                    end
                end
                S_RD: begin
                    if (bus_ack) begin
                        state <= S_WR;
                        bus_we <= 1'b1;
                        bus_periph <= dir_cur;
                        bus_addr <= dir_cur ? per_cur : ram_cur;
                        // byte cycles carry the low byte only
                        bus_wdata <= bus_byte ? (bus_rdata & BYTE_MASK) : bus_rdata;
                    end
                end
                S_WR: begin
                    if (bus_ack && null_cur) begin
                        state <= S_NUL;
                        bus_periph <= 1'b1;
                        bus_addr <= per_cur;
                        bus_wdata <= NULL_DATA;
                    end else if (bus_ack) begin
                        state <= S_IDLE;
                        bus_req <= 1'b0;
                        bus_we <= 1'b0;
                    end
                end
                S_NUL: begin
                    if (bus_ack) begin
                        state <= S_IDLE;
                        bus_req <= 1'b0;
                        bus_we <= 1'b0;
                    end
                end
            endcase
        end
    end

    // all ones until first transfer; then serving channel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lca <= LCA_RST;
        end else if (xfer_done) begin
            lca <= 4'(cur);
        end
    end

    // sticky block events, write one clears, event wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            if (apb_wr && paddr == OFS_INT_STAT) begin
                int_stat <= (int_stat & ~pwdata[NCH-1:0]) | blk_evt;
            end else begin
                int_stat <= int_stat | blk_evt;
            end
            if (apb_wr && paddr == OFS_INT_MASK) begin
                int_mask <= pwdata[NCH-1:0];
            end
        end
    end

    // interrupt level lags status by one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_mask);
        end
    end
endmodule : dmacc_top

// ===== tb/dmacc_checker.sv
`timescale 1ns/1ps
module dmacc_checker
    import dmacc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic bus_req, // dma
    input wire logic bus_we, // dma
    input wire logic bus_periph, // dma
    input wire logic bus_byte, // dma
    input wire logic [15:0] bus_addr, // dma
    input wire logic [15:0] bus_wdata, // dma
    input wire logic [15:0] bus_rdata, // dma
    input wire logic bus_ack // dma
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // apb phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // dma cycle ends
    sequence s_rd_done;
        bus_req && !bus_we && bus_ack;
    endsequence
    sequence s_ram_wr_done;
        bus_req && bus_we && !bus_periph && bus_ack;
    endsequence
    AST_APB_WAIT: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready not one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_BUS_HOLD: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we)
        && $stable(bus_periph) && $stable(bus_wdata))
        else $error("bus cycle changed before ack");
    AST_READ_FIRST: assert property ($rose(bus_req) |-> !bus_we)
        else $error("transfer did not start with read");
    AST_DIR_SWAP: assert property (s_rd_done |=> bus_req && bus_we && bus_periph != $past(bus_periph))
        else $error("write not in other space");
    AST_WDATA: assert property (s_rd_done |=>
        bus_wdata == (bus_byte ? ($past(bus_rdata) & BYTE_MASK) : $past(bus_rdata)))
        else $error("write data not the read data");
    AST_NULL_DATA: assert property (s_ram_wr_done ##1 bus_req |->
        bus_we && bus_periph && bus_wdata == NULL_DATA)
        else $error("bad null write");
    AST_SIZE_SAME: assert property (bus_req && $past(bus_req) |-> $stable(bus_byte))
        else $error("size changed in transfer");
endmodule : dmacc_checker

bind dmacc_top dmacc_checker dmacc_checker_inst (.clk, .nrst, .psel, .penable, .pready, .pslverr, .bus_req,
    .bus_we, .bus_periph, .bus_byte, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack);

// ===== tb/dmacc_mem.sv
`timescale 1ns/1ps
module dmacc_mem (
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic [3:0] lat, // ack wait
    input wire logic bus_req, // cycle on
    input wire logic bus_we, // write
    input wire logic bus_periph, // periph space
    input wire logic [15:0] bus_addr, // address
    input wire logic [15:0] bus_wdata, // write data
    output logic [15:0] bus_rdata, // read data
    output logic bus_ack, // cycle done
    output logic [15:0] wr_addr, // last write addr
    output logic [15:0] wr_data, // last write data
    output logic wr_per, // last write periph
    output int wr_cnt // writes seen
);
    logic [3:0] waited;
    // data toggles outside an answer so stale data never passes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waited <= '0;
            bus_ack <= 1'b0;
            bus_rdata <= 16'h0000;
            wr_addr <= 16'h0000;
            wr_data <= 16'h0000;
            wr_per <= 1'b0;
            wr_cnt <= 0;
        end else begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus_req && !bus_ack && waited < lat) begin
                waited <= waited + 4'h1;
            end else if (bus_req && !bus_ack) begin
                waited <= '0;
                bus_ack <= 1'b1;
                if (bus_we) begin
                    wr_addr <= bus_addr;
                    wr_data <= bus_wdata;
                    wr_per <= bus_periph;
                    wr_cnt <= wr_cnt + 1;
                end else begin
                    bus_rdata <= {bus_periph ? 4'hA : 4'h5, bus_addr[11:0]};
                end
            end
        end
    end
endmodule : dmacc_mem

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import dmacc_pkg::*;
    localparam logic [15:0] BUF_A = 16'h11A4;
    localparam logic [15:0] BUF_B = 16'h2258;
    localparam logic [15:0] PER_A = 16'h0346;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, ev;
    logic bus_req, bus_we, bus_periph, bus_byte, bus_ack, wr_per;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] xfer_req, lat;
    logic [15:0] pia_addr, bus_addr, bus_wdata, bus_rdata, wr_addr, wr_data;
    int wr_cnt, fail_count, checked;
    dmacc_top dmacc_top_inst (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .xfer_req, .pia_addr, .bus_req, .bus_we, .bus_periph, .bus_byte, .bus_addr,
        .bus_wdata, .bus_rdata, .bus_ack);
    dmacc_mem dmacc_mem_inst (.clk, .nrst, .lat, .bus_req, .bus_we, .bus_periph, .bus_addr, .bus_wdata,
        .bus_rdata, .bus_ack, .wr_addr, .wr_data, .wr_per, .wr_cnt);
    // system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic results;
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 40);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (i >= 40) begin
            fail_count++;
            results();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        cmp(rv, exp);
    endtask : rdc
    function automatic logic [7:0] ra(input int ch, input logic [2:0] idx);
        return CH_STRIDE * 8'(ch) + 8'({idx, 2'b00});
    endfunction : ra
    task automatic cfg(input int ch, input logic [15:0] con, input logic [15:0] cnt);
        apb(1'b1, ra(ch, IDX_RAM_A), 32'(BUF_A));
        apb(1'b1, ra(ch, IDX_RAM_B), 32'(BUF_B));
        apb(1'b1, ra(ch, IDX_PADR), 32'(PER_A));
        apb(1'b1, ra(ch, IDX_CNT), 32'(cnt));
        apb(1'b1, ra(ch, IDX_CON), 32'(con));
    endtask : cfg
    // pulse a request and wait for n writes
    task automatic fire(input int ch, input int n);
        int i;
        int base;
        base = wr_cnt;
        xfer_req[ch] <= 1'b1;
        @(posedge clk);
        xfer_req[ch] <= 1'b0;
        i = 0;
        while (wr_cnt < base + n && i < 80) begin
            @(posedge clk);
            i++;
        end
        repeat (3) @(posedge clk);
        if (i >= 80) begin
            fail_count++;
            results();
        end
    endtask : fire
    task automatic wchk(input logic [15:0] a, input logic [15:0] d, input logic p);
        cmp({16'h0000, wr_addr}, {16'h0000, a});
        cmp({16'h0000, wr_data}, {16'h0000, d});
        cmp(32'(wr_per), 32'(p));
    endtask : wchk
    task automatic t_reset;
        rdc(OFS_LCA, 32'h0000_000F);
        rdc(ra(0, IDX_CON), 32'h0000_0000);
        apb(1'b1, ra(3, IDX_CON), 32'hFFFF_7FFF);
        rdc(ra(3, IDX_CON), 32'h0000_7833);
        rdc(8'hFC, 32'h0000_0000);
        cmp(32'(ev), 32'h0000_0001);
    endtask : t_reset
    task automatic t_off;
        int n;
        n = wr_cnt;
        cfg(0, 16'h0001, 16'h0000);
        xfer_req[0] <= 1'b1;
        @(posedge clk);
        xfer_req[0] <= 1'b0;
        repeat (20) @(posedge clk);
        cmp(32'(wr_cnt), 32'(n));
        rdc(OFS_LCA, 32'h0000_000F);
    endtask : t_off
    // periph to ram, one-shot, then interrupt raise, mask, clear
    task automatic t_plain;
        lat <= 4'h2;
        cfg(1, 16'h8001, 16'h0000);
        fire(1, 1);
        wchk(BUF_A, {4'hA, PER_A[11:0]}, 1'b0);
        rdc(OFS_LCA, 32'h0000_0001);
        rdc(ra(1, IDX_CON), 32'h0000_0001);
        rdc(OFS_INT_STAT, 32'h0000_0002);
        cmp(32'(irq), 32'h0000_0000);
        apb(1'b1, OFS_INT_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk);
        cmp(32'(irq), 32'h0000_0001);
        apb(1'b1, OFS_INT_STAT, 32'h0000_0002);
        repeat (2) @(posedge clk);
        cmp(32'(irq), 32'h0000_0000);
        rdc(OFS_INT_STAT, 32'h0000_0000);
    endtask : t_plain
    task automatic t_byte;
        lat <= 4'h5;
        cfg(2, 16'hE011, 16'h0000);
        fire(2, 1);
        wchk(PER_A, {8'h00, BUF_A[7:0]}, 1'b1);
        rdc(OFS_LCA, 32'h0000_0002);
        lat <= 4'h0;
    endtask : t_byte
    task automatic t_null;
        cfg(3, 16'h8801, 16'h0000);
        fire(3, 2);
        cmp({16'h0000, wr_data}, {16'h0000, NULL_DATA});
        cmp(32'(wr_per), 32'h0000_0001);
        rdc(OFS_LCA, 32'h0000_0003);
    endtask : t_null
    task automatic t_pia;
        cfg(0, 16'h8021, 16'h0000);
        fire(0, 1);
        wchk(pia_addr, {4'hA, PER_A[11:0]}, 1'b0);
        rdc(OFS_LCA, 32'h0000_0000);
    endtask : t_pia
    task automatic t_pp_one;
        cfg(0, 16'h8003, 16'h0000);
        fire(0, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_A});
        fire(0, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_B});
        rdc(ra(0, IDX_CON), 32'h0000_0003);
    endtask : t_pp_one
    task automatic t_pp_cont;
        cfg(1, 16'h8012, 16'h0000);
        fire(1, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_A});
        fire(1, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_B});
        fire(1, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_A});
        rdc(ra(1, IDX_CON), 32'h0000_8012);
        apb(1'b1, ra(1, IDX_CON), 32'h0000_0000);
    endtask : t_pp_cont
    task automatic t_half;
        // post-increment mode, so the second transfer must land one word further on
        cfg(2, 16'h9000, 16'h0003);
        apb(1'b1, OFS_INT_STAT, 32'h0000_000F);
        fire(2, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_A});
        rdc(OFS_INT_STAT, 32'h0000_0000);
        fire(2, 1);
        cmp({16'h0000, wr_addr}, {16'h0000, BUF_A + STEP_WORD});
        rdc(OFS_INT_STAT, 32'h0000_0004);
        rdc(ra(2, IDX_CON), 32'h0000_9000);
    endtask : t_half
    // main sequence
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        xfer_req = '0;
        lat = '0;
        pia_addr = 16'h3A3C;
        fail_count = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_off();
        t_plain();
        t_byte();
        t_null();
        t_pia();
        t_pp_one();
        t_pp_cont();
        t_half();
        results();
    end
endmodule : tb
